// file: bench/mst_host_model.sv
// Host controller model driving the pins and the serial front end strobes.
`timescale 1ns/1ps

module mst_host_model (
	// Clock
	input  wire logic            i_mclk,
	// Host pins and requests
	output logic                 o_module_reset_n,
	output logic                 o_low_power_request,
	output logic                 o_module_select_n,
	output mst_pkg::mst_host_req_t o_host_req
);
	import mst_pkg::*;

	// ==========================================================
	// Idle levels
	initial begin
		o_module_reset_n    = 1'b1;
		o_low_power_request = 1'b0;
		o_module_select_n   = 1'b1;
		o_host_req          = '0;
	end

	// ==========================================================
	// Pin tasks, entered just after a rising edge
	task automatic reset_pulse(input int n);
		o_module_reset_n = 1'b0;
		repeat (n) @(posedge i_mclk);
		#1 o_module_reset_n = 1'b1;
	endtask : reset_pulse

	task automatic set_select_n(input logic b);
		o_module_select_n = b;
	endtask : set_select_n

	task automatic set_low_power(input logic b);
		o_low_power_request = b;
	endtask : set_low_power

	// Each strobe lasts one cycle, as the end of one serial transaction.
	// Data fields are inverted once released so stale values cannot pass.
	task automatic pulse(input mst_host_req_t r);
		mst_host_req_t idle;
		idle          = ~r;
		idle.mask_wr  = 1'b0;
		idle.pdown_wr = 1'b0;
		idle.clr      = 1'b0;
		o_host_req = r;
		@(posedge i_mclk);
		#1 o_host_req = idle;
		// One idle edge keeps back-to-back transactions apart.
		@(posedge i_mclk);
		#1;
	endtask : pulse

	task automatic write_mask(input logic [FLAG_W-1:0] m);
		mst_host_req_t r;
		r           = '0;
		r.mask_wr   = 1'b1;
		r.mask_data = m;
		pulse(r);
	endtask : write_mask

	task automatic write_pdown(input logic b);
		mst_host_req_t r;
		r            = '0;
		r.pdown_wr   = 1'b1;
		r.pdown_data = b;
		pulse(r);
	endtask : write_pdown

	task automatic read_clear(input logic [FLAG_W-1:0] s, input logic ini);
		mst_host_req_t r;
		r          = '0;
		r.clr      = 1'b1;
		r.clr_sel  = s;
		r.clr_init = ini;
		pulse(r);
	endtask : read_clear
endmodule : mst_host_model

// file: bench/tb.sv
// Self-checking testbench of the management status timing block.
`timescale 1ns/1ps

module tb;
	import mst_pkg::*;

	// ==========================================================
	// Signals
	localparam logic [31:0] INIT = 32'h0000_0014;
	localparam logic [31:0] WAKE = 32'h0000_000A;
	logic                i_mclk;
	logic                i_rst_n;
	logic                rst_pin_n;
	logic                lp_req;
	logic                sel_n;
	mst_host_req_t       req;
	logic [FLAG_W-1:0]   cond;
	logic                irq_o;
	logic                irq_oe;
	wire                 irq_pin;
	logic [FLAG_W-1:0]   flags;
	logic [FLAG_W-1:0]   mask;
	logic                init_flag;
	logic                dnr;
	logic                pdown;
	logic                low_power;
	logic                bus_en;
	logic                ready;
	int                  n_errors;
	int                  checks_done;
	int                  cycles;

	// Open drain line with a pull-up.
	assign irq_pin = irq_oe ? irq_o : 1'b1;

	mst_host_model host (
		.i_mclk              (i_mclk),
		.o_module_reset_n    (rst_pin_n),
		.o_low_power_request (lp_req),
		.o_module_select_n   (sel_n),
		.o_host_req          (req)
	);

	mst_mgmt_status #(.INIT_CYCLES(INIT), .WAKE_CYCLES(WAKE)) uut (
		.i_mclk                   (i_mclk),
		.i_rst_n                  (i_rst_n),
		.i_module_reset_n         (rst_pin_n),
		.i_low_power_request      (lp_req),
		.i_module_select_n        (sel_n),
		.i_host_req               (req),
		.i_cond                   (cond),
		.o_interrupt_request_n_o  (irq_o),
		.o_interrupt_request_n_oe (irq_oe),
		.o_flags                  (flags),
		.o_mask                   (mask),
		.o_init_flag              (init_flag),
		.o_data_not_ready         (dnr),
		.o_pdown                  (pdown),
		.o_low_power              (low_power),
		.o_bus_enable             (bus_en),
		.o_ready                  (ready)
	);

	// ==========================================================
	// Clock and timeout
	initial i_mclk = 1'b0;
	always #2.5 i_mclk = ~i_mclk;

	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			n_errors = n_errors + 1;
			finish_test();
		end
	end

	// ==========================================================
	// Helpers
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask : step

	// Waits for data-not-ready to fall, no longer than the given cycle count.
	task automatic wait_ready(input int lim);
		int k;
		k = 0;
		while (dnr !== 1'b0 && k < lim) begin
			step(1);
			k = k + 1;
		end
		check("ready time", 8'(k < lim), 8'h01);
		check("init flag", {7'h00, init_flag}, 8'h01);
		step(1);
		check("irq at start", {7'h00, irq_pin}, 8'h00);
	endtask : wait_ready

	task automatic finish_test();
		if (n_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test

	// ==========================================================
	// Tests
	initial begin
		n_errors    = 0;
		checks_done = 0;
		cycles      = 0;
		i_rst_n     = 1'b0;
		cond        = 8'h00;
		step(4);
		i_rst_n = 1'b1;
		host.set_select_n(1'b0);
		step(2);
		check("bus before ready", {7'h00, bus_en}, 8'h00);
		check("dnr at start", {7'h00, dnr}, 8'h01);
		wait_ready(int'(INIT) + 4);
		check("bus after ready", {7'h00, bus_en}, 8'h01);
		host.read_clear(8'h00, 1'b1);
		step(1);
		check("irq after init read", {7'h00, irq_pin}, 8'h01);
		// Every condition sets its own flag and pulls the line.
		for (int i = 0; i < FLAG_W; i++) begin
			cond[i] = 1'b1;
			step(1);
			check("flag set", flags, 8'(1 << i));
			cond[i] = 1'b0;
			step(1);
			check("irq on flag", {7'h00, irq_pin}, 8'h00);
			host.read_clear(8'(1 << i), 1'b0);
			check("flag cleared", flags, 8'h00);
			step(1);
			check("irq released", {7'h00, irq_pin}, 8'h01);
		end
		// A read that meets a live condition must not lose the flag.
		cond[3] = 1'b1;
		step(1);
		host.read_clear(8'h08, 1'b0);
		check("set beats clear", flags, 8'h08);
		cond[3] = 1'b0;
		host.read_clear(8'h08, 1'b0);
		// Masked condition keeps the line high until unmasked.
		host.write_mask(8'h04);
		check("mask", mask, 8'h04);
		cond[2] = 1'b1;
		step(1);
		cond[2] = 1'b0;
		step(1);
		check("masked irq", {7'h00, irq_pin}, 8'h01);
		host.write_mask(8'h00);
		step(1);
		check("unmasked irq", {7'h00, irq_pin}, 8'h00);
		host.read_clear(8'h04, 1'b0);
		// Select gating.
		host.set_select_n(1'b1);
		step(1);
		check("bus deselected", {7'h00, bus_en}, 8'h00);
		host.set_select_n(1'b0);
		step(1);
		check("bus reselected", {7'h00, bus_en}, 8'h01);
		// Low power pin.
		host.set_low_power(1'b1);
		step(1);
		check("lp pin on", {7'h00, low_power}, 8'h01);
		host.set_low_power(1'b0);
		step(1);
		check("lp pin off", {7'h00, low_power}, 8'h00);
		// Software power-down and wake.
		host.write_pdown(1'b1);
		check("pdown bit", {7'h00, pdown}, 8'h01);
		step(1);
		check("pdown power", {low_power, dnr, bus_en}, 8'h07);
		host.write_pdown(1'b0);
		step(1);
		check("waking", {ready, dnr}, 8'h01);
		wait_ready(int'(WAKE) + 4);
		host.read_clear(8'h00, 1'b1);
		// A pulse of exactly the minimum length is ignored.
		host.write_mask(8'h80);
		cond[5] = 1'b1;
		step(1);
		cond[5] = 1'b0;
		host.reset_pulse(400);
		step(1);
		check("short reset", {ready, flags[5]}, 8'h03);
		host.reset_pulse(402);
		check("long reset flags", flags, 8'h00);
		check("long reset mask", mask, 8'h00);
		step(1);
		check("long reset state", {ready, dnr, bus_en}, 8'h02);
		wait_ready(int'(INIT) + 4);
		finish_test();
	end
endmodule : tb

// file: design/mst_low_filter.sv
// Minimum low-pulse filter for the module reset pin.
`timescale 1ns/1ps

module mst_low_filter (
	// Clock and reset
	input  wire logic i_mclk,
	input  wire logic i_rst_n,
	// Pin and result
	input  wire logic i_level_n,
	output logic      o_recognised,
	output logic      o_release
);
	import mst_pkg::*;

	typedef struct packed {
		logic [RST_CNT_W-1:0] cnt;
		logic                 seen;
	} mst_filt_t;

	mst_filt_t st_r;
	mst_filt_t st_nxt;

	// ==========================================================
	// Filter
	always_comb begin
		st_nxt = st_r;
		if (!i_level_n) begin
			if (st_r.cnt != RST_MIN_CYC) begin
				st_nxt.cnt = RST_CNT_W'(st_r.cnt + 1'b1);
			end
			if (st_r.cnt == RST_MIN_CYC) begin
				st_nxt.seen = 1'b1;
			end
		end else begin
			st_nxt.cnt  = '0;
			st_nxt.seen = 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_recognised = st_r.seen;
	assign o_release    = st_r.seen & i_level_n;

	a_pulse_min_len: assert property (
		@(posedge i_mclk) disable iff (!i_rst_n)
		$rose(st_r.seen) |-> $past(st_r.cnt) == RST_MIN_CYC && !$past(i_level_n))
		else $error("Reset recognised before the minimum low time.");

endmodule : mst_low_filter

// file: design/mst_mgmt_status.sv
// Start-up sequencing, event flags, interrupt line and power control of the management logic.
`timescale 1ns/1ps

module mst_mgmt_status #(
	parameter logic [31:0] INIT_CYCLES = mst_pkg::INIT_CYC,
	parameter logic [31:0] WAKE_CYCLES = mst_pkg::WAKE_CYC
) (
	// Clock and reset
	input  wire logic                        i_mclk,
	input  wire logic                        i_rst_n,
	// Host pins
	input  wire logic                        i_module_reset_n,
	input  wire logic                        i_low_power_request,
	input  wire logic                        i_module_select_n,
	// Host register requests from the serial bus front end
	input  wire mst_pkg::mst_host_req_t      i_host_req,
	// Conditions from the optical and electrical monitors
	input  wire logic [mst_pkg::FLAG_W-1:0]  i_cond,
	// Interrupt pin, open drain
	output logic                             o_interrupt_request_n_o,
	output logic                             o_interrupt_request_n_oe,
	// Status
	output logic [mst_pkg::FLAG_W-1:0]       o_flags,
	output logic [mst_pkg::FLAG_W-1:0]       o_mask,
	output logic                             o_init_flag,
	output logic                             o_data_not_ready,
	output logic                             o_pdown,
	output logic                             o_low_power,
	output logic                             o_bus_enable,
	output logic                             o_ready
);
	import mst_pkg::*;

	typedef struct packed {
		mst_state_t        state;
		logic [FLAG_W-1:0] flags;
		logic [FLAG_W-1:0] mask;
		logic              init_flag;
		logic              dnr;
		logic              pdown;
		logic              low_power;
		logic              bus_en;
		logic              irq;
	} mst_core_t;

	mst_core_t st_r;
	mst_core_t st_nxt;

	logic              rst_seen;
	logic              rst_release;
	logic              tmr_start;
	logic [TMR_W-1:0]  tmr_load;
	logic              tmr_busy;
	logic              tmr_done;
	logic [FLAG_W-1:0] clr_bits;

	// ==========================================================
	// Interrupt cause decode, shared by the next-state logic and the checks
	function automatic logic irq_cause(input logic [FLAG_W-1:0] flags,
	                                   input logic [FLAG_W-1:0] mask,
	                                   input logic              init_flag);
		irq_cause = init_flag | (|(flags & ~mask));
	endfunction : irq_cause

	function automatic logic is_active(input mst_state_t s);
		is_active = (s == ST_READY) || (s == ST_LOWPWR) || (s == ST_WAKE);
	endfunction : is_active

	// ==========================================================
	// Sub-blocks
	mst_low_filter u_rst_filter (
		.i_mclk       (i_mclk),
		.i_rst_n      (i_rst_n),
		.i_level_n    (i_module_reset_n),
		.o_recognised (rst_seen),
		.o_release    (rst_release)
	);

	mst_timer #(
		.W (TMR_W)
	) u_timer (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_start (tmr_start),
		.i_load  (tmr_load),
		.o_busy  (tmr_busy),
		.o_done  (tmr_done)
	);

	// The start cycle and the terminal cycle add two edges, taken off the load.
	always_comb begin
		tmr_start = 1'b0;
		tmr_load  = INIT_CYCLES - TMR_MARGIN;
		if (st_r.state == ST_BOOT) begin
			tmr_start = 1'b1;
		end else if (st_r.state == ST_LOWPWR && !st_r.pdown) begin
			tmr_start = 1'b1;
			tmr_load  = WAKE_CYCLES - TMR_MARGIN;
		end
	end

	assign clr_bits = i_host_req.clr ? i_host_req.clr_sel : '0;

	// ==========================================================
	// Next state
	always_comb begin
		st_nxt = st_r;
		// Set wins over the clear-on-read of the same cycle.
		st_nxt.flags = (st_r.flags & ~clr_bits) | i_cond;
		if (i_host_req.clr && i_host_req.clr_init) begin
			st_nxt.init_flag = 1'b0;
		end
		if (i_host_req.mask_wr) begin
			st_nxt.mask = i_host_req.mask_data;
		end
		if (i_host_req.pdown_wr) begin
			st_nxt.pdown = i_host_req.pdown_data;
		end
		unique case (st_r.state)
			ST_HOLD: begin
				st_nxt.dnr = 1'b1;
				if (rst_release) begin
					st_nxt.state = ST_BOOT;
				end
			end
			ST_BOOT: begin
				st_nxt.state = ST_INIT;
			end
			ST_INIT: begin
				if (tmr_done) begin
					st_nxt.state     = ST_READY;
					st_nxt.dnr       = 1'b0;
					st_nxt.init_flag = 1'b1;
				end
			end
			ST_READY: begin
				if (st_r.pdown) begin
					st_nxt.state = ST_LOWPWR;
				end
			end
			ST_LOWPWR: begin
				st_nxt.dnr = 1'b1;
				if (!st_r.pdown) begin
					st_nxt.state = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (st_r.pdown) begin
					st_nxt.state = ST_LOWPWR;
				end else if (tmr_done) begin
					st_nxt.state     = ST_READY;
					st_nxt.dnr       = 1'b0;
					st_nxt.init_flag = 1'b1;
				end
			end
			default: begin
				st_nxt.state = ST_HOLD;
			end
		endcase
		// A recognised module reset wipes everything the host has set up.
		// The release edge itself leaves hold, since the filter forgets the pulse right after.
		if (rst_seen) begin
			st_nxt.state     = rst_release ? ST_BOOT : ST_HOLD;
			st_nxt.flags     = FLAGS_RST;
			st_nxt.mask      = MASK_RST;
			st_nxt.init_flag = 1'b0;
			st_nxt.pdown     = 1'b0;
			st_nxt.dnr       = 1'b1;
		end
		st_nxt.low_power = i_low_power_request | st_r.pdown;
		// Responding while in low power lets the host clear the power-down bit.
		st_nxt.bus_en = ~i_module_select_n & is_active(st_r.state);
		st_nxt.irq    = irq_cause(st_r.flags, st_r.mask, st_r.init_flag);
	end

	// ==========================================================
	// State register
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r.state     <= ST_BOOT;
			st_r.flags     <= FLAGS_RST;
			st_r.mask      <= MASK_RST;
			st_r.init_flag <= 1'b0;
			st_r.dnr       <= 1'b1;
			st_r.pdown     <= 1'b0;
			st_r.low_power <= 1'b0;
			st_r.bus_en    <= 1'b0;
			st_r.irq       <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign o_interrupt_request_n_o  = 1'b0;
	assign o_interrupt_request_n_oe = st_r.irq;
	assign o_flags                  = st_r.flags;
	assign o_mask                   = st_r.mask;
	assign o_init_flag              = st_r.init_flag;
	assign o_data_not_ready         = st_r.dnr;
	assign o_pdown                  = st_r.pdown;
	assign o_low_power              = st_r.low_power;
	assign o_bus_enable             = st_r.bus_en;
	assign o_ready                  = (st_r.state == ST_READY);

	// ==========================================================
	// Checks
	logic [TMR_W-1:0] start_cnt_r;

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			start_cnt_r <= '0;
		end else if (st_r.state == ST_BOOT || st_r.state == ST_HOLD) begin
			start_cnt_r <= '0;
		end else if (st_r.state == ST_INIT) begin
			start_cnt_r <= TMR_W'(start_cnt_r + 1'b1);
		end
	end

	a_init_bounded: assert property (
		@(posedge i_mclk) disable iff (!i_rst_n)
		st_r.state == ST_INIT |-> start_cnt_r < INIT_CYCLES)
		else $error("Start-up interval overran its limit.");

	a_dnr_clear_irq: assert property (
		@(posedge i_mclk) disable iff (!i_rst_n || rst_seen)
		(st_r.state == ST_INIT && tmr_done) |=> !o_data_not_ready && o_init_flag ##1 o_interrupt_request_n_oe)
		else $error("Start-up end did not clear not-ready and raise the interrupt.");

	a_bus_after_init: assert property (
		@(posedge i_mclk) disable iff (!i_rst_n)
		o_bus_enable |-> $past(is_active(st_r.state)))
		else $error("Serial bus answered before start-up finished.");

	a_lp_request_enter: assert property (
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_low_power_request |=> o_low_power)
		else $error("Low-power request was not followed.");

	a_pdown_enter: assert property (
		@(posedge i_mclk) disable iff (!i_rst_n || rst_seen)
		(i_host_req.pdown_wr && i_host_req.pdown_data) |=> ##1 o_low_power)
		else $error("Power-down bit did not reach low power.");

	a_flag_capture: assert property (
		@(posedge i_mclk) disable iff (!i_rst_n || rst_seen)
		(|i_cond) |=> (o_flags & $past(i_cond)) == $past(i_cond))
		else $error("A condition was not latched into its flag.");

	a_irq_assert: assert property (
		@(posedge i_mclk) disable iff (!i_rst_n)
		irq_cause(st_r.flags, st_r.mask, st_r.init_flag) |=> o_interrupt_request_n_oe)
		else $error("Interrupt line not driven low for an active cause.");

	a_irq_release: assert property (
		@(posedge i_mclk) disable iff (!i_rst_n)
		!irq_cause(st_r.flags, st_r.mask, st_r.init_flag) |=> !o_interrupt_request_n_oe)
		else $error("Interrupt line held after all causes were cleared.");

	a_mask_inhibit: assert property (
		@(posedge i_mclk) disable iff (!i_rst_n || rst_seen)
		(i_host_req.mask_wr && o_flags == '0 && !o_init_flag && i_cond == '0)
		|=> o_mask == $past(i_host_req.mask_data))
		else $error("Mask write was not applied.");

	a_sel_respond: assert property (
		@(posedge i_mclk) disable iff (!i_rst_n)
		(!i_module_select_n && o_ready) |=> o_bus_enable)
		else $error("Selected module did not answer the serial bus.");

	a_sel_release: assert property (
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_module_select_n |=> !o_bus_enable)
		else $error("Deselected module kept answering the serial bus.");

	a_wake_start: assert property (
		@(posedge i_mclk) disable iff (!i_rst_n || rst_seen)
		(st_r.state == ST_LOWPWR && !st_r.pdown) |=> st_r.state == ST_WAKE && tmr_busy)
		else $error("Power-down clear did not start the wake interval.");

endmodule : mst_mgmt_status

// file: design/mst_timer.sv
// Loadable down-counter that bounds the start-up and wake intervals.
`timescale 1ns/1ps

module mst_timer #(
	parameter int W = 32
) (
	// Clock and reset
	input  wire logic         i_mclk,
	input  wire logic         i_rst_n,
	// Control
	input  wire logic         i_start,
	input  wire logic [W-1:0] i_load,
	// Status
	output logic              o_busy,
	output logic              o_done
);
	import mst_pkg::*;

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         busy;
	} mst_tmr_t;

	mst_tmr_t st_r;
	mst_tmr_t st_nxt;

	// ==========================================================
	// Counter
	always_comb begin
		st_nxt = st_r;
		if (i_start) begin
			st_nxt.cnt  = i_load;
			st_nxt.busy = 1'b1;
		end else if (st_r.busy) begin
			st_nxt.cnt = W'(st_r.cnt - 1'b1);
			if (st_r.cnt <= 1) begin
				st_nxt.busy = 1'b0;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_busy = st_r.busy;
	assign o_done = st_r.busy & (st_r.cnt <= 1) & ~i_start;

	a_timer_done_stops: assert property (
		@(posedge i_mclk) disable iff (!i_rst_n)
		(o_done && !i_start) |=> !o_busy)
		else $error("Timer kept running after its terminal count.");

endmodule : mst_timer

// file: include/mst_pkg.sv
// Shared constants and types for the management status timing block.
package mst_pkg;

	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_KHZ      = 200000;
	localparam int unsigned T_INIT_MS    = 2000;
	localparam int unsigned T_RST_MIN_US = 2;
	localparam int unsigned T_PDOFF_MS   = 300;
	localparam int unsigned INIT_CYC     = T_INIT_MS * CLK_KHZ;
	localparam int unsigned WAKE_CYC     = T_PDOFF_MS * CLK_KHZ;
	localparam int unsigned RST_MIN_INT  = (T_RST_MIN_US * CLK_KHZ + 999) / 1000;

	// ==========================================================
	// Widths and reset values
	localparam int unsigned RST_CNT_W = 9;
	localparam int unsigned TMR_W     = 32;
	localparam int unsigned FLAG_W    = 8;
	localparam logic [RST_CNT_W-1:0] RST_MIN_CYC = RST_CNT_W'(RST_MIN_INT);
	localparam logic [TMR_W-1:0]     TMR_MARGIN  = 32'h0000_0002;
	localparam logic [FLAG_W-1:0]    MASK_RST    = 8'h00;
	localparam logic [FLAG_W-1:0]    FLAGS_RST   = 8'h00;

	// ==========================================================
	// Flag positions
	localparam int unsigned FLAG_RX_LOS   = 0;
	localparam int unsigned FLAG_TX_FAULT = 1;

	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0] {
		ST_HOLD   = 3'b000,
		ST_BOOT   = 3'b001,
		ST_INIT   = 3'b010,
		ST_READY  = 3'b011,
		ST_LOWPWR = 3'b100,
		ST_WAKE   = 3'b101
	} mst_state_t;

	// ==========================================================
	// Host side requests, each taken at the end of its bus transaction
	typedef struct packed {
		logic              mask_wr;
		logic [FLAG_W-1:0] mask_data;
		logic              pdown_wr;
		logic              pdown_data;
		logic              clr;
		logic [FLAG_W-1:0] clr_sel;
		logic              clr_init;
	} mst_host_req_t;

endpackage : mst_pkg
